// File: rbt_ctrl.sv
`timescale 1ns/1ps
module rbt_ctrl
  import rbt_pkg::*;
(
  input  wire logic        CLOCK,
  input  wire logic        ARST_N,
  input  wire logic [3:0]  ADDR,
  input  wire logic [15:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [15:0] RDATA,
  rbt_link_if.ctl          LINK
);
  logic [15:0] word_q, word_d, rdata_q, rdata_d, res_q;
  logic [1:0]  mode_q, mode_d;
  logic [STB_W-1:0] stb_q, stb_d;
  logic [3:0]  pix_q, pix_d;

  always_comb begin
    word_d = (WR && ADDR == REG_CTRL_WORD) ? WDATA : word_q;
    mode_d = (WR && ADDR == REG_MODE) ? WDATA[1:0] : mode_q;
    pix_d  = (WR && ADDR == REG_PIXEL) ? WDATA[3:0] : pix_q;
    stb_d  = {1'b0, 1'b0, stb_q[STB_POE], stb_q[STB_DOE], 6'h00};
    if (WR && ADDR == REG_STROBE) begin
      stb_d = WDATA[STB_W-1:0];
    end
    case (ADDR)
      REG_CTRL_WORD: rdata_d = word_q;
      REG_MODE:      rdata_d = {14'h0000, mode_q};
      REG_PIXEL:     rdata_d = {12'h000, pix_q};
      REG_RESULT:    rdata_d = res_q;
      REG_STATUS:    rdata_d = {13'h0000, LINK.pixel_from_dev, LINK.frame_data_oe, LINK.fifo_ready};
      default:       rdata_d = 16'h0000;
    endcase
    if (!RD) rdata_d = 16'h0000;
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      word_q  <= 16'h0000;
      mode_q  <= 2'h0;
      stb_q   <= '0;
      pix_q   <= 4'h0;
      rdata_q <= 16'h0000;
      res_q   <= 16'h0000;
    end else begin
      word_q  <= word_d;
      mode_q  <= mode_d;
      stb_q   <= stb_d;
      pix_q   <= pix_d;
      rdata_q <= rdata_d;
      res_q   <= LINK.frame_data_oe ? LINK.frame_data_from_dev : res_q;
    end
  end

  // controller drives every link control from registers
  assign LINK.line_mode          = mode_q[MODE_LINE];
  assign LINK.single_clock_strap = mode_q[MODE_TCS];
  assign LINK.ctrl_reg_load      = stb_q[STB_CRL];
  assign LINK.data_latch_load    = stb_q[STB_DLL];
  assign LINK.source_path_enable = stb_q[STB_SRC] && !stb_q[STB_DOE];
  assign LINK.swap_select        = stb_q[STB_SWAP];
  assign LINK.pixel_bit_select   = mode_q[MODE_LINE] ? pix_q :
                                   {stb_q[STB_FRD], stb_q[STB_FWR], stb_q[STB_RME], stb_q[STB_LME]};
  assign LINK.data_out_drive_n   = !stb_q[STB_DOE];
  assign LINK.pixel_out_drive_n  = !stb_q[STB_POE];
  assign LINK.frame_data_to_dev  = word_q;
  assign LINK.pixel_to_dev       = pix_q[0];
  assign RDATA                   = rdata_q;
endmodule

// File: rbt_fifo.sv
`timescale 1ns/1ps
module rbt_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
  logic [AW:0]      cnt_q, cnt_d;
  logic             push, pop;

  always_comb begin
    push  = in_valid && in_ready;
    pop   = out_valid && out_ready;
    wr_d  = push ? wr_q + 1'b1 : wr_q;
    rd_d  = pop ? rd_q + 1'b1 : rd_q;
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];
endmodule

// File: rbt_link_if.sv
`timescale 1ns/1ps
interface rbt_link_if;
  import rbt_pkg::*;
  logic        line_mode;
  logic        single_clock_strap;
  logic        ctrl_reg_load;
  logic        data_latch_load;
  logic        source_path_enable;
  logic        swap_select;
  logic [3:0]  pixel_bit_select;
  logic        data_out_drive_n;
  logic        pixel_out_drive_n;
  logic [15:0] frame_data_to_dev;
  logic [15:0] frame_data_from_dev;
  logic        frame_data_oe;
  logic        pixel_to_dev;
  logic        pixel_from_dev;
  logic        pixel_oe;
  logic        fifo_ready;
  wire  [15:0] frame_data_port = frame_data_oe ? frame_data_from_dev : frame_data_to_dev;
  wire         pixel_io        = pixel_oe ? pixel_from_dev : pixel_to_dev;
  modport dev (
    input  line_mode, single_clock_strap, ctrl_reg_load, data_latch_load, source_path_enable,
    input  swap_select, pixel_bit_select, data_out_drive_n, pixel_out_drive_n,
    input  frame_data_to_dev, pixel_to_dev,
    output frame_data_from_dev, frame_data_oe, pixel_from_dev, pixel_oe, fifo_ready
  );
  modport ctl (
    output line_mode, single_clock_strap, ctrl_reg_load, data_latch_load, source_path_enable,
    output swap_select, pixel_bit_select, data_out_drive_n, pixel_out_drive_n,
    output frame_data_to_dev, pixel_to_dev,
    input  frame_data_from_dev, frame_data_oe, pixel_from_dev, pixel_oe, fifo_ready
  );
endinterface

// File: rbt_link_sva.sv
`timescale 1ns/1ps
module rbt_link_sva (
  input wire logic       CLOCK,
  input wire logic       ARST_N,
  input wire logic       line_mode,
  input wire logic       ctrl_reg_load,
  input wire logic       data_latch_load,
  input wire logic       source_path_enable,
  input wire logic [3:0] pixel_bit_select,
  input wire logic       data_out_drive_n,
  input wire logic       pixel_out_drive_n,
  input wire logic       frame_data_oe,
  input wire logic       pixel_oe,
  input wire logic       fifo_ready
);
  wire fifo_wr = pixel_bit_select[2] && !line_mode;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!ARST_N);
  ctl_pulse_a: assert property (ctrl_reg_load |=> !ctrl_reg_load)
    else $error("control load strobe too long");
  data_pulse_a: assert property (data_latch_load |=> !data_latch_load)
    else $error("data latch strobe too long");
  data_on_a: assert property ($fell(data_out_drive_n) |=> frame_data_oe)
    else $error("data port not driven");
  data_off_a: assert property (data_out_drive_n |=> !frame_data_oe)
    else $error("data port driven while disabled");
  pix_on_a: assert property ((!pixel_out_drive_n && line_mode) |=> pixel_oe)
    else $error("pixel port not driven");
  pix_line_a: assert property (!line_mode |=> !pixel_oe)
    else $error("pixel port driven in block mode");
  pix_off_a: assert property (pixel_out_drive_n |=> !pixel_oe)
    else $error("pixel port driven while disabled");
  src_quiet_a: assert property (!data_out_drive_n |-> !source_path_enable)
    else $error("source enable during write");
  fifo_fill_a: assert property ($fell(fifo_ready) |-> $past(fifo_wr) || $past(fifo_wr, 2))
    else $error("fifo full without write");
  cover property ($rose(frame_data_oe));
  cover property ($fell(fifo_ready));
  cover property (pixel_oe && line_mode);
endmodule

// File: rbt_pkg.sv
package rbt_pkg;
  localparam int DATA_W      = 16;
  localparam int SHIFT_W     = 4;
  localparam int FIFO_DEPTH  = 16;
  localparam int FIFO_AW     = 4;
  // control word layout
  localparam int CTL_FUNC_LSB  = 0;
  localparam int CTL_RMASK_LSB = 4;
  localparam int CTL_LMASK_LSB = 8;
  localparam int CTL_SHIFT_LSB = 12;
  localparam int FIELD_W       = 4;
  localparam logic [15:0] CTL_RESET = 16'h0000;
  // controller register offsets
  localparam logic [3:0] REG_CTRL_WORD = 4'h0;
  localparam logic [3:0] REG_MODE      = 4'h1;
  localparam logic [3:0] REG_STROBE    = 4'h2;
  localparam logic [3:0] REG_DATA_OUT  = 4'h3;
  localparam logic [3:0] REG_PIXEL     = 4'h4;
  localparam logic [3:0] REG_RESULT    = 4'h5;
  localparam logic [3:0] REG_STATUS    = 4'h6;
  // strobe register bits
  localparam int STB_CRL  = 0;
  localparam int STB_DLL  = 1;
  localparam int STB_SRC  = 2;
  localparam int STB_SWAP = 3;
  localparam int STB_FWR  = 4;
  localparam int STB_FRD  = 5;
  localparam int STB_DOE  = 6;
  localparam int STB_POE  = 7;
  localparam int STB_LME  = 8;
  localparam int STB_RME  = 9;
  localparam int STB_W    = 10;
  // mode register bits
  localparam int MODE_LINE = 0;
  localparam int MODE_TCS  = 1;
endpackage

// File: rbt_unit.sv
// Local design decisions: the register offsets and the strobed register port.
`timescale 1ns/1ps
module rbt_unit
  import rbt_pkg::*;
(
  input  wire logic CLOCK,
  input  wire logic ARST_N,
  rbt_link_if.dev   LINK
);
  // control and data input latches
  logic [15:0] ctl_q, ctl_d;
  logic [15:0] din_q, din_d;
  // source pipeline: barrel input latch and source data latch
  logic [15:0] barrel_q, barrel_d;
  logic [15:0] src_q, src_d;
  // combine stage
  logic [15:0] result_q, result_d;
  logic        pix_in_q, pix_in_d;
  // output drive stage
  logic        doe_q, doe_d;
  logic        poe_q, poe_d;
  logic        pout_q, pout_d;
  logic        strap_q, strap_d;
  // fifo side
  logic        fifo_wr, fifo_rd, fifo_in_ready, fifo_out_valid;
  logic [15:0] fifo_out;
  // datapath nets
  logic [31:0] shin;
  logic [15:0] shifted, lmask, rmask, mask, dest, fres;
  logic [3:0]  shamt, lm_cnt, rm_cnt, func, pix_sel;
  logic        block_mode, lme, rme;

  // sixteen two-operand functions: code is truth table over (s,d)
  function automatic logic [15:0] logic_fn(input logic [3:0] f, input logic [15:0] s, input logic [15:0] d);
    logic [15:0] r;
    r = '0;
    for (int i = 0; i < 16; i++) begin
      r[i] = f[{s[i], d[i]}];
    end
    return r;
  endfunction

  // left mask protects leading bits, right mask trailing bits
  function automatic logic [15:0] edge_mask(input logic [3:0] n, input logic left);
    logic [15:0] m;
    m = left ? (16'hffff >> n) : (16'hffff << n);
    return m;
  endfunction

  // mode decode and pin reuse
  // all four pixel address pins double as block-mode strobes
  always_comb begin
    block_mode = !LINK.line_mode;
    pix_sel    = LINK.pixel_bit_select;
    lme        = block_mode && LINK.pixel_bit_select[0];
    rme        = block_mode && LINK.pixel_bit_select[1];
    fifo_wr    = block_mode && LINK.pixel_bit_select[2];
    fifo_rd    = block_mode && LINK.pixel_bit_select[3];
  end

  // control word and data input latch
  always_comb begin
    ctl_d = ctl_q;
    din_d = din_q;
    if (LINK.ctrl_reg_load) begin
      ctl_d = LINK.frame_data_to_dev;
    end
    if (LINK.data_latch_load) begin
      din_d = LINK.frame_data_to_dev;
    end
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      ctl_q <= CTL_RESET;
      din_q <= 16'h0000;
    end else begin
      ctl_q <= ctl_d;
      din_q <= din_d;
    end
  end

  // source pipeline, advanced only while the source path is enabled
  // barrel latch takes the word the source latch held
  always_comb begin
    barrel_d = barrel_q;
    src_d    = src_q;
    if (LINK.source_path_enable) begin
      barrel_d = src_q;
      src_d    = fifo_rd ? fifo_out : din_q;
    end
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      barrel_q <= 16'h0000;
      src_q    <= 16'h0000;
    end else begin
      barrel_q <= barrel_d;
      src_q    <= src_d;
    end
  end

  // barrel shifter over the two pipeline words
  always_comb begin
    shin    = LINK.swap_select ? {src_q, barrel_q} : {barrel_q, src_q};
    shamt   = ctl_q[CTL_SHIFT_LSB +: FIELD_W];
    shifted = 16'(shin >> (16 - 32'(shamt)));
  end

  // write mask: one pixel in line mode, edge masks in block mode
  always_comb begin
    lm_cnt = ctl_q[CTL_LMASK_LSB +: FIELD_W];
    rm_cnt = ctl_q[CTL_RMASK_LSB +: FIELD_W];
    lmask  = edge_mask(lm_cnt, 1'b1);
    rmask  = edge_mask(rm_cnt, 1'b0);
    mask   = 16'hffff;
    if (LINK.line_mode) begin
      mask = 16'h8000 >> pix_sel;
    end else begin
      if (lme) begin
        mask = mask & lmask;
      end
      if (rme) begin
        mask = mask & rmask;
      end
    end
  end

  // combine stage
  // function code is a truth table indexed by {source, destination}
  always_comb begin
    func = ctl_q[CTL_FUNC_LSB +: FIELD_W];
    dest = din_q;
    if (LINK.line_mode) begin
      fres = logic_fn(func, {16{pix_in_q}}, dest);
    end else begin
      fres = logic_fn(func, shifted, dest);
    end
    result_d = (fres & mask) | (dest & ~mask);
    pix_in_d = LINK.line_mode ? LINK.pixel_to_dev : pix_in_q;
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      result_q <= 16'h0000;
      pix_in_q <= 1'b0;
    end else begin
      result_q <= result_d;
      pix_in_q <= pix_in_d;
    end
  end

  // output drive stage
  // strap only registered: one clock serves both settings
  always_comb begin
    doe_d   = !LINK.data_out_drive_n;
    poe_d   = !LINK.pixel_out_drive_n && LINK.line_mode;
    pout_d  = result_d[4'hf - pix_sel];
    strap_d = LINK.single_clock_strap;
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      doe_q   <= 1'b0;
      poe_q   <= 1'b0;
      pout_q  <= 1'b0;
      strap_q <= 1'b0;
    end else begin
      doe_q   <= doe_d;
      poe_q   <= poe_d;
      pout_q  <= pout_d;
      strap_q <= strap_d;
    end
  end

  rbt_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_fifo (
    .clk       (CLOCK),
    .arst_n    (ARST_N),
    .in_valid  (fifo_wr),
    .in_ready  (fifo_in_ready),
    .in_data   (din_q),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_rd),
    .out_data  (fifo_out)
  );

  assign LINK.frame_data_from_dev = result_q;
  assign LINK.frame_data_oe       = doe_q;
  assign LINK.pixel_from_dev      = pout_q;
  assign LINK.pixel_oe            = poe_q;
  assign LINK.fifo_ready          = fifo_in_ready;
endmodule

// File: rbt_unit_tb.sv
`timescale 1ns/1ps
module rbt_unit_tb;
  import rbt_pkg::*;
  logic        CLOCK = 0;
  logic        ARST_N = 0;
  logic        WR = 0;
  logic        RD = 0;
  logic [3:0]  ADDR = '0;
  logic [15:0] WDATA = '0;
  logic [15:0] RDATA;
  int          mismatches = 0;
  int          check_count = 0;
  logic [15:0] fq[$];
  logic [15:0] rq[$];
  logic        rd_d = 0;
  logic        oe_d = 0;
  rbt_link_if rbt_link_if_i ();
  rbt_unit rbt_unit_i (.CLOCK(CLOCK), .ARST_N(ARST_N), .LINK(rbt_link_if_i.dev));
  rbt_ctrl rbt_ctrl_i (.CLOCK(CLOCK), .ARST_N(ARST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
                       .RDATA(RDATA), .LINK(rbt_link_if_i.ctl));
  rbt_link_sva rbt_link_sva_i (.CLOCK(CLOCK), .ARST_N(ARST_N), .line_mode(rbt_link_if_i.line_mode),
    .ctrl_reg_load(rbt_link_if_i.ctrl_reg_load), .data_latch_load(rbt_link_if_i.data_latch_load),
    .source_path_enable(rbt_link_if_i.source_path_enable), .pixel_bit_select(rbt_link_if_i.pixel_bit_select),
    .data_out_drive_n(rbt_link_if_i.data_out_drive_n), .pixel_out_drive_n(rbt_link_if_i.pixel_out_drive_n),
    .frame_data_oe(rbt_link_if_i.frame_data_oe), .pixel_oe(rbt_link_if_i.pixel_oe),
    .fifo_ready(rbt_link_if_i.fifo_ready));
  always #5 CLOCK = ~CLOCK;
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out;
    if (fq.size() != 0 || rq.size() != 0) begin
      mismatches++;
    end
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    RD <= 1'b0;
    @(posedge CLOCK);
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    rq.push_back(exp);
    ADDR <= a;
    RD <= 1'b1;
    WR <= 1'b0;
    @(posedge CLOCK);
  endtask
  task automatic idle(input int n);
    WR <= 1'b0;
    RD <= 1'b0;
    repeat (n) @(posedge CLOCK);
  endtask
  // word onto the frame data lines, then strobes
  task automatic put(input logic [15:0] w, input logic [15:0] stb);
    wr(REG_CTRL_WORD, w);
    wr(REG_DATA_OUT, w);
    wr(REG_STROBE, stb);
  endtask
  // results appear when the data port starts driving
  always @(posedge CLOCK) begin
    if (rd_d) begin
      chk(RDATA, rq.pop_front(), "rdata");
    end
    if (rbt_link_if_i.frame_data_oe === 1'b1 && !oe_d) begin
      chk(rbt_link_if_i.frame_data_port, fq.pop_front(), "frame");
    end
    rd_d <= RD;
    oe_d <= rbt_link_if_i.frame_data_oe === 1'b1;
  end
  initial begin
    repeat (20000) @(posedge CLOCK);
    mismatches++;
    close_out;
  end
  initial begin
    logic [15:0] s1, s2, d, sh, r, m, w;
    logic [31:0] cat;
    logic [3:0]  n, lm, rm;
    logic        sw, le, re;
    void'($urandom(56));
    repeat (5) @(posedge CLOCK);
    ARST_N <= 1'b1;
    for (int f = 0; f < 16; f++) begin
      {n, lm, rm, sw, le, re} = 15'($urandom);
      s1 = 16'($urandom);
      s2 = 16'($urandom);
      d = 16'($urandom);
      w = {n, lm, rm, 4'(f)};
      put(w, 16'h1 << STB_CRL);
      put(s1, (16'h1 << STB_DLL) | (16'h1 << STB_SRC));
      put(s2, (16'h1 << STB_DLL) | (16'h1 << STB_SRC));
      wr(REG_STROBE, 16'h1 << STB_SRC);
      put(d, 16'h1 << STB_DLL);
      cat = sw ? {s2, s1} : {s1, s2};
      sh = 16'(cat >> (16 - n));
      m = (le ? 16'hffff >> lm : 16'hffff) & (re ? 16'hffff << rm : 16'hffff);
      for (int i = 0; i < 16; i++) begin
        r[i] = w[{sh[i], d[i]}];
      end
      fq.push_back((r & m) | (d & ~m));
      wr(REG_STROBE, (16'h1 << STB_DOE) | {6'h0, re, le, 4'h0, sw, 3'h0});
      idle(4);
      wr(REG_STROBE, 16'h0);
      idle(3);
    end
    // fill past full, then drain
    for (int i = 0; i < 17; i++) begin
      chk(16'(rbt_link_if_i.fifo_ready), 16'(i < 16), "fifo_ready");
      wr(REG_STROBE, 16'h1 << STB_FWR);
      idle(3);
    end
    for (int i = 0; i < 16; i++) begin
      wr(REG_STROBE, 16'h1 << STB_FRD);
      idle(2);
    end
    chk(16'(rbt_link_if_i.fifo_ready), 16'h1, "fifo_drained");
    wr(REG_MODE, 16'h3);
    wr(REG_PIXEL, 16'h5);
    put(16'h0006, 16'h1 << STB_CRL);
    wr(REG_STROBE, 16'h1 << STB_POE);
    idle(3);
    chk(16'(rbt_link_if_i.pixel_oe), 16'h1, "pixel_oe");
    chk({15'h0000, rbt_link_if_i.pixel_io}, {15'h0000, ~d[10]}, "pixel_io");
    rd(REG_MODE, 16'h3);
    rd(REG_PIXEL, 16'h5);
    rd(REG_STATUS, {13'h0000, ~d[10], 2'h1});
    wr(REG_STROBE, 16'h0);
    rd(4'hf, 16'h0);
    idle(4);
    chk(16'(rbt_link_if_i.pixel_oe), 16'h0, "pixel_off");
    close_out;
  end
endmodule
